// >>> dci_cke_sync.sv
// two-flop level synchroniser for the clock-enable pin
// assumes the pin may change with no relation to mclk
`timescale 1ns/1ps
`default_nettype none
module dci_cke_sync
    import dci_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic cke_pin,
    output logic      cke_level
);
    typedef struct packed {
        logic meta;
        logic stable;
    } dci_sync_s;

    dci_sync_s s;
    dci_sync_s next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = cke_pin;
        next_s.stable = s.meta;
        if (!rst_n) begin
            next_s = '0;
        end
    end

    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    assign cke_level = s.stable;

endmodule : dci_cke_sync
`default_nettype wire

// >>> dci_ctl_model.sv
// controller-side model driving command, clock-enable, odt and write-mask pins
// assumes mclk is the device clock; every pin changes on its falling edge
`timescale 1ns/1ps
`default_nettype none
module dci_ctl_model
    import dci_pkg::*;
(
    input  wire logic                  mclk,
    output logic                       cke,
    output logic                       cs_n,
    output logic                       ras_n,
    output logic                       cas_n,
    output logic                       we_n,
    output logic [DCI_ADDR_W-1:0]      addr,
    output logic [DCI_BA_W-1:0]        ba,
    output logic                       odt,
    output logic [1:0]                 dm_rise,
    output logic [1:0]                 dm_fall,
    output logic                       wr_beat
);
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, odt, wr_beat} = 7'h78;
        {addr, ba, dm_rise, dm_fall} = '0;
    end
    task automatic cmd(input logic [3:0] code, input logic [DCI_ADDR_W-1:0] a, input logic [DCI_BA_W-1:0] b);
        @(negedge mclk);
        {cs_n, ras_n, cas_n, we_n} <= code;
        addr <= a;
        ba   <= b;
    endtask : cmd
    // deselect; unselected lines flip so stale values never pass for valid
    task automatic idle();
        @(negedge mclk);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
        addr    <= ~addr;
        ba      <= ~ba;
        wr_beat <= 1'b0;
        dm_rise <= ~dm_rise;
        dm_fall <= ~dm_fall;
    endtask : idle
    task automatic pins(input logic k, input logic o);
        @(negedge mclk);
        cke <= k;
        odt <= o;
    endtask : pins
    task automatic beat(input logic [1:0] r, input logic [1:0] f);
        @(negedge mclk);
        wr_beat <= 1'b1;
        dm_rise <= r;
        dm_fall <= f;
    endtask : beat
endmodule : dci_ctl_model
`default_nettype wire

// >>> dci_ctrl_in.sv
// control-input front end of a ddr2 device: command capture, cke power states,
// input buffer gating, on-die termination steering and dm/rdqs pin function
// assumes mclk is the ck/ck# rising crossing and keeps running inside the device;
// cs_n, ras_n, cas_n, we_n, addr, ba, odt and dm are launched by the controller
// against that crossing; cke may arrive at any time while in self refresh
//
// Notes on behaviour
// [R1] capture address and control on clock crossing
// [R2] read data launched on both crossing directions
// [R3] cke high keeps clocks, buffers, drivers on
// [R4] cke low: idle to precharge/self refresh, else active
// [R5] cke sampled on clock for entry/exit
// [R6] self refresh exit seen without the clock edge
// [R7] controller keeps cke high during accesses
// [R8] power-down keeps only ck, odt, cke buffers
// [R9] self refresh keeps only the cke buffer
// [R10] chip select high masks the command
// [R11] chip select is part of command code
// [R12] registered odt switches termination on/off
// [R13] x4/x8 terminate dq, dqs, rdqs, dm
// [R14] x16 terminate all dq, both strobes, masks
// [R15] odt ignored when termination disabled in emrs
// [R16] x8 rdqs mirrors dqs, masking disabled
// [R17] emrs bit picks dm or rdqs pin
// [R18] half-width x16 uses lower lanes, lower strobe; not built here, width_cfg 3 terminates no dq lanes
// [R19] command encoded on ras, cas, we with cs
// [R20] dm high drops data, sampled both edges
// [R21] controller times odt like other controls
`timescale 1ns/1ps
`default_nettype none
module dci_ctrl_in
    import dci_pkg::*;
#(
    parameter int unsigned ADDR_W = DCI_ADDR_W,
    parameter int unsigned BA_W   = DCI_BA_W
)(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              cke,
    input  wire logic              cs_n,
    input  wire logic              ras_n,
    input  wire logic              cas_n,
    input  wire logic              we_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [BA_W-1:0]   ba,
    input  wire logic              odt,
    input  wire logic [1:0]        dm_rise,
    input  wire logic [1:0]        dm_fall,
    input  wire logic              wr_beat,
    input  wire logic              bank_open,
    input  wire logic [1:0]        width_cfg,
    input  wire logic              odt_en_cfg,
    input  wire logic              rdqs_en_cfg,
    output logic [1:0]             pwr_state,
    output logic                   clk_en,
    output logic                   ibuf_cmd_en,
    output logic                   ibuf_ck_en,
    output logic                   ibuf_odt_en,
    output logic                   drv_en,
    output logic                   cmd_valid,
    output logic [3:0]             cmd_code,
    output logic [ADDR_W-1:0]      cmd_addr,
    output logic [BA_W-1:0]        cmd_ba,
    output logic                   launch_rise,
    output logic                   launch_fall,
    output logic                   odt_on,
    output logic [DCI_DQ_W-1:0]    term_dq,
    output logic                   term_dqs_l,
    output logic                   term_dqs_u,
    output logic                   term_dm_l,
    output logic                   term_dm_u,
    output logic                   term_rdqs,
    output logic                   dm_is_mask,
    output logic                   rdqs_on,
    output logic [3:0]             wr_keep
);
    typedef struct packed {
        dci_pwr_e            pwr;
        logic                cke_q;
        logic                clk_en;
        logic                ibuf_cmd;
        logic                ibuf_ck;
        logic                ibuf_odt;
        logic                drv_en;
        logic                cmd_valid;
        logic [3:0]          cmd_code;
        logic [ADDR_W-1:0]   cmd_addr;
        logic [BA_W-1:0]     cmd_ba;
        logic                launch_rise;
        logic                launch_fall;
        logic                odt_on;
        logic [DCI_DQ_W-1:0] term_dq;
        logic                term_dqs_l;
        logic                term_dqs_u;
        logic                term_dm_l;
        logic                term_dm_u;
        logic                term_rdqs;
        logic                dm_is_mask;
        logic                rdqs_on;
        logic [3:0]          wr_keep;
    } dci_state_s;

    dci_state_s s;
    dci_state_s next_s;
    logic       cke_async;

    // the cke path used for self refresh exit; the pad receiver stays powered
    dci_cke_sync u_cke_sync (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .cke_pin   (cke),
        .cke_level (cke_async)
    );

    // dq lanes that exist for a given organisation
    function automatic logic [DCI_DQ_W-1:0] dq_lanes(input logic [1:0] w);
        unique case (w)
            DCI_W_X4:  dq_lanes = 16'h000F;
            DCI_W_X8:  dq_lanes = 16'h00FF;
            DCI_W_X16: dq_lanes = 16'hFFFF;
            default:   dq_lanes = 16'h0000;
        endcase
    endfunction : dq_lanes

    logic [3:0] pin_code;
    logic       sr_req;
    logic       x8_rdqs;
    logic       x16;
    assign pin_code = {cs_n, ras_n, cas_n, we_n};                        // R11 R19
    assign sr_req   = (pin_code == DCI_CMD_REFRESH);
    assign x8_rdqs  = (width_cfg == DCI_W_X8) && rdqs_en_cfg;              // R17
    assign x16      = (width_cfg == DCI_W_X16);

    always_comb begin
        next_s = s;
        next_s.cke_q = cke;                                                // R5
        // power state walk
        unique case (s.pwr)
            DCI_PWR_ACTIVE: begin
                if (s.cke_q && !cke) begin                                 // R5
                    if (sr_req && !bank_open) begin
                        next_s.pwr = DCI_PWR_SREF;                         // R4
                    end else if (bank_open) begin
                        next_s.pwr = DCI_PWR_APD;                          // R4
                    end else begin
                        next_s.pwr = DCI_PWR_PPD;                          // R4
                    end
                end
            end
            DCI_PWR_PPD, DCI_PWR_APD: begin
                if (cke) begin
                    next_s.pwr = DCI_PWR_ACTIVE;                           // R5
                end
            end
            DCI_PWR_SREF: begin
                // the synchroniser still shows the pre-entry high for one edge,
                // so the pin must agree before the exit is taken
                if (cke_async && cke) begin
                    next_s.pwr = DCI_PWR_ACTIVE;                           // R6
                end
            end
        endcase
        // receivers and drivers follow the state being entered
        next_s.clk_en   = (next_s.pwr == DCI_PWR_ACTIVE);                  // R3
        next_s.drv_en   = (next_s.pwr == DCI_PWR_ACTIVE);                  // R3
        next_s.ibuf_cmd = (next_s.pwr == DCI_PWR_ACTIVE);                  // R3 R8
        next_s.ibuf_ck  = (next_s.pwr != DCI_PWR_SREF);                    // R8 R9
        next_s.ibuf_odt = (next_s.pwr != DCI_PWR_SREF);                    // R8 R9
        // command capture on the crossing
        next_s.cmd_valid = 1'b0;
        if (s.ibuf_cmd && cke && !cs_n) begin                              // R1 R10
            next_s.cmd_valid = 1'b1;
            next_s.cmd_code  = pin_code;                                   // R11 R19
            next_s.cmd_addr  = addr;                                       // R1
            next_s.cmd_ba    = ba;                                         // R1
        end
        // read launch alternates rising and falling crossing
        if (next_s.drv_en) begin
            next_s.launch_rise = !s.launch_rise;                           // R2
            next_s.launch_fall = s.launch_rise;                            // R2
        end else begin
            next_s.launch_rise = 1'b0;
            next_s.launch_fall = 1'b0;
        end
        // termination
        next_s.odt_on     = next_s.ibuf_odt && odt && odt_en_cfg;          // R12 R15 R9
        next_s.term_dq    = next_s.odt_on ? dq_lanes(width_cfg) : '0;      // R13 R14
        next_s.term_dqs_l = next_s.odt_on;                                 // R13 R14
        next_s.term_dqs_u = next_s.odt_on && x16;                          // R14
        next_s.term_dm_l  = next_s.odt_on;                                 // R13 R14
        next_s.term_dm_u  = next_s.odt_on && x16;                          // R14
        next_s.term_rdqs  = next_s.odt_on && x8_rdqs;                      // R13
        // shared dm / rdqs pin
        next_s.dm_is_mask = !x8_rdqs;                                      // R17
        next_s.rdqs_on    = x8_rdqs;                                       // R16
        next_s.wr_keep    = 4'h0;
        if (wr_beat) begin
            if (x8_rdqs) begin
                next_s.wr_keep = 4'hF;                                     // R16
            end else begin
                next_s.wr_keep = {~dm_fall, ~dm_rise};                     // R20
            end
            if (!x16) begin
                next_s.wr_keep[3] = 1'b0;
                next_s.wr_keep[1] = 1'b0;
            end
        end
        if (!rst_n) begin
            next_s          = '0;
            next_s.pwr      = DCI_RST_PWR;
            next_s.cke_q    = DCI_RST_CKE;
            next_s.cmd_code = DCI_CMD_DESELECT;
            next_s.wr_keep  = DCI_RST_KEEP;
            next_s.clk_en   = 1'b1;
            next_s.drv_en   = 1'b1;
            next_s.ibuf_cmd = 1'b1;
            next_s.ibuf_ck  = 1'b1;
            next_s.ibuf_odt = 1'b1;
            next_s.dm_is_mask = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    assign pwr_state   = s.pwr;
    assign clk_en      = s.clk_en;
    assign ibuf_cmd_en = s.ibuf_cmd;
    assign ibuf_ck_en  = s.ibuf_ck;
    assign ibuf_odt_en = s.ibuf_odt;
    assign drv_en      = s.drv_en;
    assign cmd_valid   = s.cmd_valid;
    assign cmd_code    = s.cmd_code;
    assign cmd_addr    = s.cmd_addr;
    assign cmd_ba      = s.cmd_ba;
    assign launch_rise = s.launch_rise;
    assign launch_fall = s.launch_fall;
    assign odt_on      = s.odt_on;
    assign term_dq     = s.term_dq;
    assign term_dqs_l  = s.term_dqs_l;
    assign term_dqs_u  = s.term_dqs_u;
    assign term_dm_l   = s.term_dm_l;
    assign term_dm_u   = s.term_dm_u;
    assign term_rdqs   = s.term_rdqs;
    assign dm_is_mask  = s.dm_is_mask;
    assign rdqs_on     = s.rdqs_on;
    assign wr_keep     = s.wr_keep;

    default clocking dci_cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_cs_mask;
        cs_n |=> !cmd_valid;
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("command taken with chip select high"); // R10

    property p_code;
        cmd_valid |-> cmd_code == $past(pin_code) && cmd_addr == $past(addr) && !cmd_code[3];
    endproperty
    a_code: assert property (p_code) else $error("captured command differs from pins"); // R1 R11

    property p_apd;
        (s.pwr == DCI_PWR_ACTIVE) && s.cke_q && !cke && bank_open |=> (s.pwr == DCI_PWR_APD);
    endproperty
    a_apd: assert property (p_apd) else $error("open row did not enter active power-down"); // R4

    property p_ppd;
        (s.pwr == DCI_PWR_ACTIVE) && s.cke_q && !cke && !bank_open && !sr_req
            |=> (s.pwr == DCI_PWR_PPD) ##1 (cke || s.pwr == DCI_PWR_PPD);
    endproperty
    a_ppd: assert property (p_ppd) else $error("idle banks did not enter precharge power-down"); // R4 R5

    property p_pd_bufs;
        (s.pwr == DCI_PWR_PPD || s.pwr == DCI_PWR_APD) |-> ibuf_ck_en && ibuf_odt_en && !ibuf_cmd_en && !drv_en;
    endproperty
    a_pd_bufs: assert property (p_pd_bufs) else $error("wrong buffers during power-down"); // R8 R3

    property p_sr_bufs;
        (s.pwr == DCI_PWR_SREF) |-> !ibuf_ck_en && !ibuf_odt_en && !odt_on && !clk_en;
    endproperty
    a_sr_bufs: assert property (p_sr_bufs) else $error("buffer left on in self refresh"); // R9

    property p_sr_exit;
        (s.pwr == DCI_PWR_SREF) && cke_async && cke |=> (s.pwr == DCI_PWR_ACTIVE) && clk_en;
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit missed"); // R6

    property p_sr_hold;
        (s.pwr == DCI_PWR_SREF) && !cke |=> (s.pwr == DCI_PWR_SREF);
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("self refresh left with cke low"); // R6 R9

    property p_odt_ignore;
        !odt_en_cfg |=> !odt_on && term_dq == '0;
    endproperty
    a_odt_ignore: assert property (p_odt_ignore) else $error("termination on while disabled"); // R15 R12

    property p_x16_term;
        odt_on && $past(x16) |-> term_dq == 16'hFFFF && term_dqs_u && term_dm_u;
    endproperty
    a_x16_term: assert property (p_x16_term) else $error("x16 termination incomplete"); // R14

    property p_launch;
        drv_en ##1 drv_en |-> launch_rise != $past(launch_rise) && launch_fall == $past(launch_rise);
    endproperty
    a_launch: assert property (p_launch) else $error("launch phases not alternating"); // R2

    property p_rdqs;
        rdqs_on |-> !dm_is_mask && (wr_keep == 4'h0 || wr_keep == 4'h5);
    endproperty
    a_rdqs: assert property (p_rdqs) else $error("masking active with read strobe"); // R16 R17

    c_sref: cover property ((s.pwr == DCI_PWR_ACTIVE) ##1 (s.pwr == DCI_PWR_SREF) ##[1:20] (s.pwr == DCI_PWR_ACTIVE));
    c_apd:  cover property ((s.pwr == DCI_PWR_APD) ##1 (s.pwr == DCI_PWR_ACTIVE));
    c_odt:  cover property (odt_on && term_dqs_u);
    c_mask: cover property (wr_keep == 4'h2);

endmodule : dci_ctrl_in
`default_nettype wire

// >>> dci_ctrl_in_tb.sv
// self-checking bench for the control-input front end
// assumes the controller model drives all command-side pins
`timescale 1ns/1ps
`default_nettype none
module dci_ctrl_in_tb;
    import dci_pkg::*;
    logic                  mclk, rst_n, bank_open, odt_en_cfg, rdqs_en_cfg, cke, cs_n, ras_n, cas_n, we_n, odt, wr_beat;
    logic [1:0]            width_cfg, pwr_state, ba, cmd_ba, dm_rise, dm_fall;
    logic [DCI_ADDR_W-1:0] addr, cmd_addr;
    logic                  clk_en, ibuf_cmd_en, ibuf_ck_en, ibuf_odt_en, drv_en, cmd_valid, launch_rise, launch_fall;
    logic                  odt_on, term_dqs_l, term_dqs_u, term_dm_l, term_dm_u, term_rdqs, dm_is_mask, rdqs_on;
    logic [3:0]            cmd_code, wr_keep;
    logic [DCI_DQ_W-1:0]   term_dq;
    logic [19:0]           last;
    logic                  r0;
    int                    n_mismatch, n_checks, cyc, k;
    dci_ctl_model ctl_u (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .addr(addr), .ba(ba), .odt(odt), .dm_rise(dm_rise), .dm_fall(dm_fall), .wr_beat(wr_beat));
    dci_ctrl_in dut_u (.mclk(mclk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .addr(addr), .ba(ba), .odt(odt), .dm_rise(dm_rise), .dm_fall(dm_fall), .wr_beat(wr_beat),
        .bank_open(bank_open), .width_cfg(width_cfg), .odt_en_cfg(odt_en_cfg), .rdqs_en_cfg(rdqs_en_cfg),
        .pwr_state(pwr_state), .clk_en(clk_en), .ibuf_cmd_en(ibuf_cmd_en), .ibuf_ck_en(ibuf_ck_en),
        .ibuf_odt_en(ibuf_odt_en), .drv_en(drv_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_ba(cmd_ba), .launch_rise(launch_rise), .launch_fall(launch_fall),
        .odt_on(odt_on), .term_dq(term_dq), .term_dqs_l(term_dqs_l), .term_dqs_u(term_dqs_u),
        .term_dm_l(term_dm_l), .term_dm_u(term_dm_u), .term_rdqs(term_rdqs), .dm_is_mask(dm_is_mask),
        .rdqs_on(rdqs_on), .wr_keep(wr_keep));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic send(input logic [3:0] c);
        logic [DCI_ADDR_W-1:0] a;
        a = {10'h2A5, c};
        ctl_u.cmd(c, a, c[1:0]);
        ctl_u.idle();
        if (!c[3]) last = {c, a, c[1:0]};
        chk(cmd_valid, !c[3]);
        chk({cmd_code, cmd_addr, cmd_ba}, last);
    endtask : send
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        {rst_n, bank_open, odt_en_cfg, rdqs_en_cfg, width_cfg} = 6'h0A;
        repeat (5) @(negedge mclk);
        chk({pwr_state, clk_en, drv_en, ibuf_cmd_en, ibuf_ck_en, ibuf_odt_en, cmd_valid, cmd_code, odt_on,
             dm_is_mask, rdqs_on, wr_keep}, 19'b00_11111_0_1000_0_10_0000);
        rst_n = 1'b1;
        for (int c = 0; c < 16; c++) send(c[3:0]);
        ctl_u.cmd(4'h3, 14'h0123, 2'h1);
        send(4'h5);
        ctl_u.idle();
        chk(cmd_valid, 1'b0);
        r0 = launch_rise;
        chk(launch_rise ^ launch_fall, 1'b1);
        ctl_u.idle();
        chk({launch_rise, launch_fall}, {~r0, r0});
        $display("test commands done");
        ctl_u.pins(1'b0, 1'b0);
        ctl_u.idle();
        chk({pwr_state, clk_en, drv_en, ibuf_cmd_en, ibuf_ck_en, ibuf_odt_en, launch_rise, launch_fall},
            9'b01_000_11_00);
        ctl_u.cmd(4'h3, 14'h0001, 2'h0);
        ctl_u.idle();
        chk(cmd_valid, 1'b0);
        ctl_u.pins(1'b1, 1'b0);
        ctl_u.idle();
        chk({pwr_state, clk_en, drv_en, ibuf_cmd_en}, 5'b00_111);
        bank_open = 1'b1;
        ctl_u.pins(1'b0, 1'b0);
        ctl_u.idle();
        chk(pwr_state, DCI_PWR_APD);
        ctl_u.pins(1'b1, 1'b0);
        ctl_u.idle();
        chk(pwr_state, DCI_PWR_ACTIVE);
        bank_open = 1'b0;
        ctl_u.cmd(DCI_CMD_REFRESH, 14'h0000, 2'h0);
        ctl_u.pins(1'b0, 1'b1);
        ctl_u.idle();
        chk({pwr_state, ibuf_cmd_en, ibuf_ck_en, ibuf_odt_en, odt_on}, 6'b11_0000);
        ctl_u.idle();
        chk({pwr_state, odt_on}, 3'b110);
        ctl_u.pins(1'b1, 1'b0);
        k = 0;
        while (pwr_state !== DCI_PWR_ACTIVE && k < 4) begin
            ctl_u.idle();
            k++;
        end
        chk({pwr_state, k < 4}, 3'b001);
        $display("test power done");
        for (int w = 0; w < 8; w++) begin
            width_cfg = w[1:0];
            rdqs_en_cfg = w[2];
            ctl_u.pins(1'b1, 1'b1);
            ctl_u.idle();
            r0 = (w[1:0] == DCI_W_X8) && w[2];
            k = (w[1:0] == DCI_W_X16);
            chk({odt_on, term_dqs_l, term_dm_l, term_dqs_u, term_dm_u, term_rdqs, dm_is_mask, rdqs_on},
                {3'b111, k[0], k[0], r0, ~r0, r0});
            chk(term_dq, (w[1:0] == 0) ? 16'h000F : (w[1:0] == 1) ? 16'h00FF : {16{k[0]}});
        end
        odt_en_cfg = 1'b0;
        ctl_u.pins(1'b1, 1'b1);
        ctl_u.idle();
        chk({odt_on, term_dq}, 17'h0_0000);
        odt_en_cfg = 1'b1;
        ctl_u.pins(1'b1, 1'b0);
        ctl_u.idle();
        chk(odt_on, 1'b0);
        $display("test termination done");
        {width_cfg, rdqs_en_cfg} = 3'b100;
        ctl_u.beat(2'b01, 2'b10);
        ctl_u.idle();
        chk(wr_keep, 4'b0110);
        ctl_u.beat(2'b10, 2'b10);
        ctl_u.idle();
        chk(wr_keep, 4'b0101);
        width_cfg = DCI_W_X8;
        ctl_u.beat(2'b01, 2'b00);
        ctl_u.idle();
        chk(wr_keep, 4'b0100);
        rdqs_en_cfg = 1'b1;
        ctl_u.beat(2'b11, 2'b11);
        ctl_u.idle();
        chk(wr_keep, 4'b0101);
        $display("test write mask done");
        complete_run();
    end
endmodule : dci_ctrl_in_tb
`default_nettype wire

// >>> dci_pkg.sv
// constants and types for the ddr2 control-input front end
// assumes mclk stands for the ck/ck# rising crossing of the memory clock
package dci_pkg;

    typedef enum logic [1:0] {
        DCI_PWR_ACTIVE = 2'b00,
        DCI_PWR_PPD    = 2'b01,
        DCI_PWR_APD    = 2'b10,
        DCI_PWR_SREF   = 2'b11
    } dci_pwr_e;

    // organisation codes on the width_cfg port
    localparam logic [1:0] DCI_W_X4  = 2'h0;
    localparam logic [1:0] DCI_W_X8  = 2'h1;
    localparam logic [1:0] DCI_W_X16 = 2'h2;

    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] DCI_CMD_REFRESH  = 4'h1;
    localparam logic [3:0] DCI_CMD_DESELECT = 4'h8;

    localparam int unsigned DCI_ADDR_W = 14;
    localparam int unsigned DCI_BA_W   = 2;
    localparam int unsigned DCI_DQ_W   = 16;
    localparam int unsigned DCI_SYNC_STAGES = 2;

    localparam dci_pwr_e   DCI_RST_PWR  = DCI_PWR_ACTIVE;
    localparam logic       DCI_RST_CKE  = 1'b0;
    localparam logic [3:0] DCI_RST_KEEP = 4'h0;

endpackage : dci_pkg
